// [logic/uart_async_dev.sv]
// Device end: asynchronous serial port with 8-bit and 9-bit frames.
// Assumes baud ticks are one-cycle pulses on sys_clk_i and software keeps its own rules.
//
// Summary of operation
// - 8-bit frame: start, eight data, stop
// - Data bits travel least significant first
// - 8-bit rate from timer ticks /16 or /32
// - Transmit starts at next divide-16 rollover
// - Start, data, stop; done flag at stop
// - Frame start only while receive enable set
// - Falling edge on receive line starts frame
// - 8-bit accept: flag clear, check off or stop
// - Accept loads buffer, ninth bit, done flag
// - After mid stop, hunt for next edge
// - Majority of samples at ticks 7,8,9
// - High start bit abandons the frame
// - 9-bit frame adds programmable ninth bit
// - Ninth transmit bit captured at buffer write
// - 9-bit send order; done flag at stop
// - 9-bit accept at mid ninth bit
// - Fixed 9-bit mode: oscillator /32 or /64
// - Timer 9-bit mode differs only by source
// - Framing error sticky, cleared by software only
// - View select picks error flag or mode bit
// - Software keeps view select for error access
// - Timer 2 select per direction
// - Address frames need station address match
`timescale 1ns/1ns
module uart_async_dev
  import uart_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  uart_link_if.dev_end link,
  input wire logic t1_tick_i,
  input wire logic t2_tick_i,
  input wire logic t1_double_i,
  input wire logic osc_half_i,
  input wire logic tx_timer2_select_i,
  input wire logic rx_timer2_select_i,
  input wire logic error_view_select_i,
  input wire logic serial_control_reg_wr_i,
  input wire logic [7:0] serial_control_reg_wdata_i,
  output logic [7:0] serial_control_reg_rdata_o,
  input wire logic buf_wr_i,
  input wire logic [7:0] buf_wdata_i,
  output logic [7:0] buf_rdata_o,
  input wire logic [7:0] station_addr_i,
  input wire logic [7:0] addr_mask_i
);

  logic mode_select_high_q, mode_low_q, multiproc_check_bit_q, rx_enable_bit_q;
  logic tx_ninth_bit_q, rx_ninth_bit_q, tx_done_flag_q, rx_done_flag_q, frame_error_flag_q;
  logic [1:0] mode;
  logic async_on, nine;
  logic t1_half_q, t1_rate, osc_tick, tx_tick, rx_tick;
  logic [1:0] osc_cnt_q;
  logic [3:0] tx_cnt_q, tx_left_q;
  logic tx_roll, tx_pend_q, tx_busy_q, tx_line_q, ti_set;
  logic [10:0] tx_next_q, tx_shift_q;
  logic rx_s1_q, rx_s2_q, rx_prev_q, rx_fall;
  rx_state_t rx_state_q;
  logic [3:0] rx_cnt_q, rx_idx_q;
  logic [1:0] rx_smp_q;
  logic [7:0] rx_byte_q, rx_buf_q;
  logic rx_mid, bit_v, is_stop, is_ninth, accept8, accept9, rx_load, load_bit, fe_set;

  assign mode = {mode_select_high_q, mode_low_q};
  assign async_on = (mode != MODE_SYNC);
  assign nine = mode[1];

  ////////////////////////////////////////////////////////////////////////////
  // Bit-rate ticks

  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
      t1_half_q <= 1'b0;
    else if (t1_tick_i)
      t1_half_q <= ~t1_half_q;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i || osc_tick)
      osc_cnt_q <= 2'h0;
    else
      osc_cnt_q <= osc_cnt_q + 2'h1;
  end

  assign t1_rate = t1_tick_i & (t1_double_i | t1_half_q);
  assign osc_tick = (osc_cnt_q == (osc_half_i ? OSC_DIV2_LAST : OSC_DIV4_LAST));
  // Fixed mode uses the oscillator, timer modes pick a timer per direction
  assign tx_tick = (mode == MODE_FIXED9) ? osc_tick :
                   (tx_timer2_select_i ? t2_tick_i : t1_rate);
  assign rx_tick = (mode == MODE_FIXED9) ? osc_tick :
                   (rx_timer2_select_i ? t2_tick_i : t1_rate);

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter

  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
      tx_cnt_q <= 4'h0;
    else if (tx_tick)
      tx_cnt_q <= tx_cnt_q + 4'h1;
  end

  assign tx_roll = tx_tick & (tx_cnt_q == OVS_LAST);
  assign ti_set = tx_roll & tx_busy_q & (tx_left_q == 4'h1);

  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      tx_pend_q <= 1'b0;
      tx_next_q <= LINE_IDLE_WORD;
    end
    else if (buf_wr_i && async_on)
    begin
      tx_pend_q <= 1'b1;
      tx_next_q <= frame_bits(nine, tx_ninth_bit_q, buf_wdata_i);
    end
    else if (tx_roll && (!tx_busy_q || tx_left_q == 4'h0))
      tx_pend_q <= 1'b0;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      tx_busy_q <= 1'b0;
      tx_line_q <= 1'b1;
      tx_shift_q <= LINE_IDLE_WORD;
      tx_left_q <= 4'h0;
    end
    else if (tx_roll)
    begin
      if (tx_busy_q && tx_left_q != 4'h0)
      begin
        tx_line_q <= tx_shift_q[0];
        tx_shift_q <= {1'b1, tx_shift_q[10:1]};
        tx_left_q <= tx_left_q - 4'h1;
      end
      else if (tx_pend_q)
      begin
        tx_busy_q <= 1'b1;
        tx_line_q <= tx_next_q[0];
        tx_shift_q <= {1'b1, tx_next_q[10:1]};
        tx_left_q <= frame_len(nine) - 4'h1;
      end
      else
      begin
        tx_busy_q <= 1'b0;
        tx_line_q <= 1'b1;
      end
    end
  end

  assign link.dev_tx = tx_line_q;

  ////////////////////////////////////////////////////////////////////////////
  // Receiver

  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      rx_prev_q <= 1'b1;
    end
    else
    begin
      rx_s1_q <= link.dev_rx;
      rx_s2_q <= rx_s1_q;
      rx_prev_q <= rx_s2_q;
    end
  end

  assign rx_fall = rx_prev_q & ~rx_s2_q;
  assign rx_mid = (rx_state_q == RX_FRAME) & rx_tick & (rx_cnt_q == SMP_C);
  assign bit_v = majority3(rx_smp_q[0], rx_smp_q[1], rx_s2_q);
  assign is_stop = (rx_idx_q == frame_len(nine) - 4'h1);
  assign is_ninth = nine & (rx_idx_q == IDX_NINTH);
  assign accept8 = ~nine & is_stop & ~rx_done_flag_q
                   & (~multiproc_check_bit_q | bit_v);
  assign accept9 = is_ninth & ~rx_done_flag_q & (~multiproc_check_bit_q
                   | (bit_v & addr_match(rx_byte_q, station_addr_i, addr_mask_i)));
  assign rx_load = rx_mid & (accept8 | accept9);
  assign load_bit = bit_v;
  assign fe_set = rx_mid & is_stop & ~bit_v;

  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      rx_state_q <= RX_HUNT;
      rx_cnt_q <= 4'h0;
      rx_idx_q <= 4'h0;
      rx_smp_q <= 2'h0;
      rx_byte_q <= 8'h00;
    end
    else
    begin
      case (rx_state_q)
        RX_HUNT:
        begin
          if (rx_fall && rx_enable_bit_q && async_on)
          begin
            rx_state_q <= RX_FRAME;
            rx_cnt_q <= 4'h0;
            rx_idx_q <= 4'h0;
          end
        end
        RX_FRAME:
        begin
          if (rx_tick)
          begin
            rx_cnt_q <= rx_cnt_q + 4'h1;
            if (rx_cnt_q == SMP_A)
              rx_smp_q[0] <= rx_s2_q;
            if (rx_cnt_q == SMP_B)
              rx_smp_q[1] <= rx_s2_q;
            if (rx_cnt_q == OVS_LAST)
              rx_idx_q <= rx_idx_q + 4'h1;
            if (rx_mid)
            begin
              if (rx_idx_q == 4'h0 && bit_v)
                rx_state_q <= RX_HUNT;
              else if (rx_idx_q != 4'h0 && rx_idx_q <= IDX_DATA_LAST)
                rx_byte_q <= {bit_v, rx_byte_q[7:1]};
              if (is_stop)
                rx_state_q <= RX_HUNT;
            end
          end
        end
        default:
          rx_state_q <= RX_HUNT;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
      rx_buf_q <= 8'h00;
    else if (rx_load)
      rx_buf_q <= rx_byte_q;
  end

  assign buf_rdata_o = rx_buf_q;

  ////////////////////////////////////////////////////////////////////////////
  // Control register

  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      {mode_select_high_q, mode_low_q, multiproc_check_bit_q, rx_enable_bit_q} <= CTRL_RESET[7:4];
      tx_ninth_bit_q <= CTRL_RESET[SC_TX_NINTH];
    end
    else if (serial_control_reg_wr_i)
    begin
      if (!error_view_select_i)
        mode_select_high_q <= serial_control_reg_wdata_i[SC_MODE_HIGH];
      mode_low_q <= serial_control_reg_wdata_i[SC_MODE_LOW];
      multiproc_check_bit_q <= serial_control_reg_wdata_i[SC_MP_CHECK];
      rx_enable_bit_q <= serial_control_reg_wdata_i[SC_RX_EN];
      tx_ninth_bit_q <= serial_control_reg_wdata_i[SC_TX_NINTH];
    end
  end

  // Hardware set wins over a software write in the same cycle
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      rx_ninth_bit_q <= CTRL_RESET[SC_RX_NINTH];
      tx_done_flag_q <= CTRL_RESET[SC_TX_DONE];
      rx_done_flag_q <= CTRL_RESET[SC_RX_DONE];
      frame_error_flag_q <= 1'b0;
    end
    else
    begin
      if (rx_load)
        rx_ninth_bit_q <= load_bit;
      else if (serial_control_reg_wr_i)
        rx_ninth_bit_q <= serial_control_reg_wdata_i[SC_RX_NINTH];
      if (ti_set)
        tx_done_flag_q <= 1'b1;
      else if (serial_control_reg_wr_i)
        tx_done_flag_q <= serial_control_reg_wdata_i[SC_TX_DONE];
      if (rx_load)
        rx_done_flag_q <= 1'b1;
      else if (serial_control_reg_wr_i)
        rx_done_flag_q <= serial_control_reg_wdata_i[SC_RX_DONE];
      if (fe_set)
        frame_error_flag_q <= 1'b1;
      else if (serial_control_reg_wr_i && error_view_select_i)
        frame_error_flag_q <= serial_control_reg_wdata_i[SC_MODE_HIGH];
    end
  end

  assign serial_control_reg_rdata_o = {error_view_select_i ? frame_error_flag_q : mode_select_high_q,
                         mode_low_q, multiproc_check_bit_q, rx_enable_bit_q,
                         tx_ninth_bit_q, rx_ninth_bit_q, tx_done_flag_q, rx_done_flag_q};

endmodule // uart_async_dev

// [logic/uart_link_if.sv]
// Serial lines between the device port and the remote node.
// Assumes the testbench joins both ends through one instance.
`timescale 1ns/1ns
interface uart_link_if;
  logic dev_tx;
  logic dev_rx;
  modport dev_end (output dev_tx, input dev_rx);
  modport node_end (input dev_tx, output dev_rx);
endinterface

// [logic/uart_pkg.sv]
// Shared constants, types and helpers for the asynchronous serial link.
// Assumes both ends run on one system clock.
package uart_pkg;

  // Control register bit positions
  localparam int SC_RX_DONE = 0;
  localparam int SC_TX_DONE = 1;
  localparam int SC_RX_NINTH = 2;
  localparam int SC_TX_NINTH = 3;
  localparam int SC_RX_EN = 4;
  localparam int SC_MP_CHECK = 5;
  localparam int SC_MODE_LOW = 6;
  localparam int SC_MODE_HIGH = 7;

  // Serial modes
  localparam logic [1:0] MODE_SYNC = 2'h0;
  localparam logic [1:0] MODE_ASYNC8 = 2'h1;
  localparam logic [1:0] MODE_FIXED9 = 2'h2;
  localparam logic [1:0] MODE_TIMER9 = 2'h3;

  // Oversampling counter and sample points
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] SMP_A = 4'h6;
  localparam logic [3:0] SMP_B = 4'h7;
  localparam logic [3:0] SMP_C = 4'h8;

  // Frame lengths and bit positions
  localparam logic [3:0] LEN_8BIT = 4'hA;
  localparam logic [3:0] LEN_9BIT = 4'hB;
  localparam logic [3:0] IDX_NINTH = 4'h9;
  localparam logic [3:0] IDX_DATA_LAST = 4'h8;

  // Oscillator divider terminal counts
  localparam logic [1:0] OSC_DIV2_LAST = 2'h1;
  localparam logic [1:0] OSC_DIV4_LAST = 2'h3;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [10:0] LINE_IDLE_WORD = 11'h7FF;

  typedef enum logic {RX_HUNT, RX_FRAME} rx_state_t;

  function automatic logic majority3(input logic a, input logic b, input logic c);
    return (a & b) | (a & c) | (b & c);
  endfunction

  function automatic logic [3:0] frame_len(input logic nine);
    return nine ? LEN_9BIT : LEN_8BIT;
  endfunction

  // Start bit in bit 0, data LSb first, ninth bit in 9-bit frames only, stop bit
  function automatic logic [10:0] frame_bits(input logic nine, input logic ninth,
                                             input logic [7:0] data);
    return nine ? {1'b1, ninth, data, 1'b0} : {2'b11, data, 1'b0};
  endfunction

  function automatic logic addr_match(input logic [7:0] b, input logic [7:0] addr,
                                      input logic [7:0] mask);
    logic [7:0] bcast;
    bcast = addr | mask;
    return (((b ^ addr) & mask) == 8'h00) || ((b & bcast) == bcast);
  endfunction

endpackage

// [logic/uart_remote_node.sv]
// Remote end: asynchronous serial node with a two-entry transmit buffer.
// Assumes bit_cycles_i is the bit period in sys_clk_i cycles, at least 2.
`timescale 1ns/1ns
module uart_remote_node
  import uart_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  uart_link_if.node_end link,
  input wire logic [15:0] bit_cycles_i,
  input wire logic nine_bit_i,
  input wire logic tx_valid_i,
  input wire logic [8:0] tx_data_i,
  output logic tx_ready_o,
  output logic rx_valid_o,
  output logic [8:0] rx_data_o,
  output logic rx_frame_err_o
);

  logic [8:0] fifo_mem [0:1];
  logic wr_ptr_q, rd_ptr_q, push, pop;
  logic [1:0] fill_q;
  logic tx_busy_q, tx_line_q, tx_bit_end;
  logic [15:0] tx_cyc_q, rx_cyc_q;
  logic [3:0] tx_left_q, rx_idx_q;
  logic [10:0] tx_shift_q, tx_frame;
  logic rx_s1_q, rx_s2_q, rx_prev_q;
  rx_state_t rx_state_q;
  logic [7:0] rx_byte_q;
  logic rx_ninth_q;

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry transmit buffer

  assign tx_ready_o = (fill_q != 2'h2);
  assign push = tx_valid_i & tx_ready_o;
  assign pop = ~tx_busy_q & (fill_q != 2'h0);

  always_ff @(posedge sys_clk_i)
  begin
    if (push)
      fifo_mem[wr_ptr_q] <= tx_data_i;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      fill_q <= 2'h0;
    end
    else
    begin
      if (push)
        wr_ptr_q <= ~wr_ptr_q;
      if (pop)
        rd_ptr_q <= ~rd_ptr_q;
      if (push && !pop)
        fill_q <= fill_q + 2'h1;
      else if (pop && !push)
        fill_q <= fill_q - 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter

  assign tx_frame = frame_bits(nine_bit_i, fifo_mem[rd_ptr_q][8], fifo_mem[rd_ptr_q][7:0]);
  assign tx_bit_end = tx_busy_q & (tx_cyc_q == 16'h0000);

  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      tx_busy_q <= 1'b0;
      tx_line_q <= 1'b1;
      tx_shift_q <= LINE_IDLE_WORD;
      tx_left_q <= 4'h0;
      tx_cyc_q <= 16'h0000;
    end
    else if (pop)
    begin
      tx_busy_q <= 1'b1;
      tx_line_q <= tx_frame[0];
      tx_shift_q <= {1'b1, tx_frame[10:1]};
      tx_left_q <= frame_len(nine_bit_i) - 4'h1;
      tx_cyc_q <= bit_cycles_i - 16'h0001;
    end
    else if (tx_bit_end)
    begin
      tx_cyc_q <= bit_cycles_i - 16'h0001;
      if (tx_left_q == 4'h0)
      begin
        tx_busy_q <= 1'b0;
        tx_line_q <= 1'b1;
      end
      else
      begin
        tx_line_q <= tx_shift_q[0];
        tx_shift_q <= {1'b1, tx_shift_q[10:1]};
        tx_left_q <= tx_left_q - 4'h1;
      end
    end
    else if (tx_busy_q)
      tx_cyc_q <= tx_cyc_q - 16'h0001;
  end

  assign link.dev_rx = tx_line_q;

  ////////////////////////////////////////////////////////////////////////////
  // Receiver

  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      rx_prev_q <= 1'b1;
    end
    else
    begin
      rx_s1_q <= link.dev_tx;
      rx_s2_q <= rx_s1_q;
      rx_prev_q <= rx_s2_q;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      rx_state_q <= RX_HUNT;
      rx_cyc_q <= 16'h0000;
      rx_idx_q <= 4'h0;
      rx_byte_q <= 8'h00;
      rx_ninth_q <= 1'b0;
      rx_valid_o <= 1'b0;
      rx_data_o <= 9'h000;
      rx_frame_err_o <= 1'b0;
    end
    else
    begin
      rx_valid_o <= 1'b0;
      case (rx_state_q)
        RX_HUNT:
        begin
          if (rx_prev_q && !rx_s2_q)
          begin
            rx_state_q <= RX_FRAME;
            rx_cyc_q <= bit_cycles_i >> 1;
            rx_idx_q <= 4'h0;
            rx_ninth_q <= 1'b0;
          end
        end
        RX_FRAME:
        begin
          if (rx_cyc_q != 16'h0000)
            rx_cyc_q <= rx_cyc_q - 16'h0001;
          else
          begin
            rx_cyc_q <= bit_cycles_i - 16'h0001;
            rx_idx_q <= rx_idx_q + 4'h1;
            if (rx_idx_q == 4'h0 && rx_s2_q)
              rx_state_q <= RX_HUNT;
            else if (rx_idx_q == frame_len(nine_bit_i) - 4'h1)
            begin
              rx_state_q <= RX_HUNT;
              rx_valid_o <= 1'b1;
              rx_data_o <= {rx_ninth_q, rx_byte_q};
              rx_frame_err_o <= ~rx_s2_q;
            end
            else if (nine_bit_i && rx_idx_q == IDX_NINTH)
              rx_ninth_q <= rx_s2_q;
            else if (rx_idx_q != 4'h0)
              rx_byte_q <= {rx_s2_q, rx_byte_q[7:1]};
          end
        end
        default:
          rx_state_q <= RX_HUNT;
      endcase
    end
  end

endmodule // uart_remote_node

// [testbench/async_uart_modes_fe_tb.sv]
// Self-checking bench: device end and remote node joined by one serial link.
// Assumes 32-cycle bits on both ends: ticks every 2 cycles, fixed mode at half clock.
`timescale 1ns/1ns
module async_uart_modes_fe_tb;
  logic sys_clk_i, nrst_i, t1_tick_i, t2_tick_i, t1_double_i, osc_half_i;
  logic tx_timer2_select_i, rx_timer2_select_i, error_view_select_i, serial_control_reg_wr_i, buf_wr_i;
  logic nine_bit_i, tx_valid_i, tx_ready_o, rx_valid_o, rx_frame_err_o, m_ri, m_rb8, m_fe;
  logic [7:0] serial_control_reg_wdata_i, serial_control_reg_rdata_o, buf_wdata_i, buf_rdata_o, station_addr_i, addr_mask_i;
  logic [7:0] sh, m_buf;
  logic [15:0] bit_cycles_i;
  logic [8:0] tx_data_i, rx_data_o;
  logic [8:0] exp_q[$];
  logic [7:0] fq[$];
  int error_cnt, n_compared, cyc_n, stall_n, tick_n, k, md;
  uart_link_if link ();
  uart_async_dev uart_async_dev_inst (.sys_clk_i, .nrst_i, .link(link), .t1_tick_i,
    .t2_tick_i, .t1_double_i, .osc_half_i, .tx_timer2_select_i, .rx_timer2_select_i,
    .error_view_select_i, .serial_control_reg_wr_i, .serial_control_reg_wdata_i, .serial_control_reg_rdata_o, .buf_wr_i, .buf_wdata_i,
    .buf_rdata_o, .station_addr_i, .addr_mask_i);
  uart_remote_node uart_remote_node_inst (.sys_clk_i, .nrst_i, .link(link), .bit_cycles_i,
    .nine_bit_i, .tx_valid_i, .tx_data_i, .tx_ready_o, .rx_valid_o, .rx_data_o,
    .rx_frame_err_o);
  uart_link_assertions uart_link_assertions_inst (.sys_clk_i, .nrst_i, .dev_tx(link.dev_tx),
    .dev_rx(link.dev_rx), .nine_bit_i);
  //////////////////////////////////////////////////////////////////////////////
  // Clock, baud ticks, timeout, remote receive monitor
  initial
  begin
    sys_clk_i = 1'h0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i)
  begin
    #1;
    tick_n = tick_n + 1;
    t2_tick_i = tick_n[0];
    t1_tick_i = t1_double_i ? tick_n[0] : 1'h1;
    cyc_n = cyc_n + 1;
    if (tx_valid_i === 1'h1 && tx_ready_o !== 1'h1)
      stall_n = stall_n + 1;
    if (cyc_n == 40000)
    begin
      error_cnt = error_cnt + 1;
      $display("[ERR] %0t timeout", $time);
      end_sim;
    end
  end
  always @(posedge sys_clk_i)
  begin
    #1;
    if (rx_valid_o === 1'h1)
    begin
      chk(rx_data_o, exp_q.pop_front());
      chk({8'h00, rx_frame_err_o}, 9'h000);
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Tasks
  task automatic step(input int n = 1);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task end_sim;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  function automatic logic hit(input logic [7:0] b);
    logic [7:0] bc;
    bc = station_addr_i | addr_mask_i;
    return (((b ^ station_addr_i) & addr_mask_i) == 8'h00) || ((b & bc) == bc);
  endfunction
  task automatic wr_serial_control_reg(input logic [7:0] v);
    serial_control_reg_wdata_i = v;
    serial_control_reg_wr_i = 1'h1;
    step();
    serial_control_reg_wr_i = 1'h0;
    m_ri = v[0];
    m_rb8 = v[2];
    sh[6:0] = v[6:0];
    if (error_view_select_i)
      m_fe = v[7];
    else
      sh[7] = v[7];
    step();
  endtask
  task automatic buf_w(input logic [7:0] b);
    buf_wdata_i = b;
    buf_wr_i = 1'h1;
    step();
    buf_wr_i = 1'h0;
  endtask
  task automatic push(input logic [8:0] w);
    tx_valid_i = 1'h1;
    tx_data_i = w;
    while (tx_ready_o !== 1'h1)
      step();
    step();
    tx_valid_i = 1'h0;
    step();
  endtask
  task automatic dev_send(input logic [7:0] b, input logic n);
    int i;
    wr_serial_control_reg({sh[7:4], n, 3'h0});
    exp_q.push_back({sh[7] & n, b});
    buf_w(b);
    wr_serial_control_reg({sh[7:4], ~n, 3'h0});
    i = 0;
    while (serial_control_reg_rdata_o[1] !== 1'h1 && i < 800)
    begin
      step();
      i++;
    end
    chk(serial_control_reg_rdata_o[1], 1'h1);
    chk(link.dev_tx, 1'h1);
    step(40);
    chk(9'(exp_q.size()), 9'h000);
  endtask
  task automatic rx_frame(input logic [8:0] w);
    logic s9;
    logic acc;
    s9 = nine_bit_i ? w[8] : 1'h1;
    acc = !m_ri && (!sh[5] || (sh[7] ? w[8] && hit(w[7:0]) : s9));
    push(w);
    step(400);
    if (sh[4] && sh[7:6] != 2'h0)
    begin
      if (acc)
      begin
        m_buf = w[7:0];
        m_rb8 = sh[7] ? w[8] : s9;
        m_ri = 1'h1;
      end
      if (!sh[7] && !s9)
        m_fe = 1'h1;
    end
    chk(buf_rdata_o, m_buf);
    chk(serial_control_reg_rdata_o[0], m_ri);
    chk(serial_control_reg_rdata_o[2], m_rb8);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    {nrst_i, t1_double_i, tx_timer2_select_i, rx_timer2_select_i, error_view_select_i} = 5'h00;
    {serial_control_reg_wr_i, buf_wr_i, nine_bit_i, tx_valid_i, osc_half_i} = 5'h01;
    {serial_control_reg_wdata_i, buf_wdata_i, station_addr_i, addr_mask_i, sh, m_buf} = 48'h0;
    {m_ri, m_rb8, m_fe, tx_data_i, bit_cycles_i} = 28'h0020;
    void'($urandom(32'h0C0E1BC0));
    step(5);
    nrst_i = 1'h1;
    chk(serial_control_reg_rdata_o, 9'h000);
    chk(buf_rdata_o, 9'h000);
    chk(tx_ready_o, 1'h1);
    wr_serial_control_reg(8'h50);
    for (md = 0; md < 3; md++)
    begin
      t1_double_i = md != 1;
      tx_timer2_select_i = md == 2;
      rx_timer2_select_i = md == 2;
      dev_send(8'($urandom), 1'h0);
      rx_frame({1'h0, 8'($urandom)});
      rx_frame({1'h0, 8'($urandom)});
      wr_serial_control_reg(8'h50);
    end
    nine_bit_i = 1'h1;
    wr_serial_control_reg(8'h70);
    rx_frame({1'h0, 8'($urandom)});
    nine_bit_i = 1'h0;
    rx_frame({1'h0, 8'($urandom)});
    chk(serial_control_reg_rdata_o[7], sh[7]);
    error_view_select_i = 1'h1;
    step();
    chk(serial_control_reg_rdata_o[7], m_fe);
    wr_serial_control_reg(8'h50);
    chk(serial_control_reg_rdata_o[7:6], 2'h1);
    error_view_select_i = 1'h0;
    nine_bit_i = 1'h1;
    station_addr_i = 8'($urandom);
    addr_mask_i = 8'($urandom);
    for (md = 2; md < 4; md++)
    begin
      wr_serial_control_reg({2'(md), 6'h10});
      dev_send(8'($urandom), 1'($urandom));
      rx_frame(9'($urandom));
      wr_serial_control_reg({2'(md), 6'h30});
      rx_frame({1'h0, 8'($urandom)});
      rx_frame({1'h1, station_addr_i});
      wr_serial_control_reg({2'(md), 6'h30});
      rx_frame({1'h1, 8'($urandom)});
    end
    nine_bit_i = 1'h0;
    wr_serial_control_reg(8'h40);
    rx_frame({1'h0, 8'($urandom)});
    wr_serial_control_reg(8'h50);
    fork
      for (int i = 0; i < 4; i++)
      begin
        fq.push_back(8'($urandom));
        push({1'h0, fq[i]});
      end
      for (int j = 0; j < 4; j++)
      begin
        k = 0;
        while (serial_control_reg_rdata_o[0] !== 1'h1 && k < 1000)
        begin
          step();
          k++;
        end
        m_buf = fq[j];
        chk(buf_rdata_o, m_buf);
        wr_serial_control_reg(8'h50);
      end
    join
    chk(9'(stall_n != 0), 9'h001);
    wr_serial_control_reg(8'h00);
    buf_w(8'($urandom));
    step(400);
    chk(link.dev_tx, 1'h1);
    chk(9'(exp_q.size()), 9'h000);
    end_sim;
  end
endmodule // async_uart_modes_fe_tb

// [testbench/uart_link_assertions.sv]
// Checker for the two serial lines between the device end and the remote node.
// Assumes every bit lasts 32 clock cycles and nine_bit_i gives the frame length.
`timescale 1ns/1ns
module uart_link_assertions (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic dev_tx,
  input wire logic dev_rx,
  input wire logic nine_bit_i
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!nrst_i);
  //////////////////////////////////////////////////////////////////////////////
  // Cycle position inside the current frame, 0 while idle
  int tx_pos_q;
  int rx_pos_q;
  int last_pos;
  assign last_pos = nine_bit_i ? 351 : 319;
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i || tx_pos_q == last_pos)
      tx_pos_q <= 0;
    else if (tx_pos_q != 0 || !dev_tx)
      tx_pos_q <= tx_pos_q + 1;
  end
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i || rx_pos_q == last_pos)
      rx_pos_q <= 0;
    else if (rx_pos_q != 0 || !dev_rx)
      rx_pos_q <= rx_pos_q + 1;
  end
  //////////////////////////////////////////////////////////////////////////////
  // Line assertions
  a_tx_idle_reset: assert property (!$past(nrst_i) |-> dev_tx)
    else $error("transmit line low after reset");
  a_rx_idle_reset: assert property (!$past(nrst_i) |-> dev_rx)
    else $error("receive line low after reset");
  a_tx_start_low: assert property ($fell(dev_tx) && tx_pos_q == 0 |-> ##31 !dev_tx)
    else $error("transmit start bit too short");
  a_rx_start_low: assert property ($fell(dev_rx) && rx_pos_q == 0 |-> ##31 !dev_rx)
    else $error("receive start bit too short");
  a_tx_stop_high: assert property (tx_pos_q >= last_pos - 31 |-> dev_tx)
    else $error("transmit stop bit low");
  a_rx_stop_high: assert property (rx_pos_q >= last_pos - 31 |-> dev_rx)
    else $error("receive stop bit low");
  a_tx_bit_hold: assert property (tx_pos_q % 32 != 0 |-> $stable(dev_tx))
    else $error("transmit line moved inside a bit");
  a_rx_bit_hold: assert property (rx_pos_q % 32 != 0 |-> $stable(dev_rx))
    else $error("receive line moved inside a bit");
endmodule // uart_link_assertions
